// ---- inc/rcps_defs.svh ----
// Constants for the receiver clock-output and control-port select block
`ifndef RCPS_DEFS_SVH
`define RCPS_DEFS_SVH
`define RCPS_SYNC_W       11
`define RCPS_STRAP_WAIT   2'h3
`define RCPS_FS_CNT_W     8
`define RCPS_BCLK_BIT     1
`define RCPS_WCLK_BIT     7
`define RCPS_RATIO_WIN    6'h3F
`define RCPS_RATIO_MAX    8'hFF
`define RCPS_SLOT_PAD     8'h00
`define RCPS_BYTE_LAST    3'h7
`define RCPS_BYTE_RST     8'hFF
`endif

// ---- inc/rcps_pkg.sv ----
// Types shared by the receiver clock-output and control-port select block
package rcps_pkg;
    // Configuration bits driven by the register logic of the device
    typedef struct packed {
        logic fallback_en;      // System clock mode enable
        logic clk_div_sel;      // Recovered clock 128x select
        logic rx_disable;       // Receiver disable, tri-states clock out
        logic word_clk_master;  // Device drives bit and word clocks
    } rcps_cfg_t;

    // One stereo sample pair, 24 bits per channel
    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } rcps_sample_t;

    // Byte received on the control port
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rcps_ctl_byte_t;
endpackage : rcps_pkg

// ---- tb/rcps_host_model.sv ----
// Host controller model that moves one byte over the control port, SPI or I2C style
module rcps_host_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       use_spi,
    input  wire logic [7:0] tx,
    input  wire logic       strap0,
    input  wire logic       strap1,
    input  wire logic       sdo,
    input  wire logic       sdo_oe_n,
    output logic            ad0,
    output logic            ad1,
    output logic            sclk,
    output logic            sda,
    output logic            busy,
    output logic [7:0]      rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sel = 1'b0;
    logic ctl_serial_in = 1'b1;
    // Deselected pins fall back to their board straps
    assign ad0 = sel ? 1'b0 : strap0;
    assign ad1 = sel ? ctl_serial_in : strap1;
    // Open drain line: the pull-up wins unless someone pulls low
    assign sda = (use_spi | ctl_serial_in) & sdo_oe_n;
    initial begin
        sclk = 1'b0;
        busy = 1'b0;
        rx = 8'h00;
    end
    // One byte per request; the shift clock stands still between frames
    always @(posedge clk) begin
        if (go) begin
            busy <= 1'b1;
            sel <= use_spi;
            repeat (8) @(posedge clk);
            for (int i = 7; i >= 0; i--) begin
                ctl_serial_in <= tx[i];
                repeat (8) @(posedge clk);
                sclk <= 1'b1;
                rx[i] <= use_spi ? sdo : sda;
                repeat (8) @(posedge clk);
                sclk <= 1'b0;
            end
            repeat (8) @(posedge clk);
            sel <= 1'b0;
            ctl_serial_in <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule : rcps_host_model

// ---- tb/rcps_top_tb_top.sv ----
// Self-checking bench for the receiver clock-output and control-port select block
module rcps_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rcps_pkg::*;
    logic clk = 1'b0, rst = 1'b1, pll = 1'b0, locked = 1'b0, ext = 1'b0, ext_lvl = 1'b0, strap = 1'b0;
    logic pll_run = 1'b0, ext_run = 1'b0, a1 = 1'b0, ad2 = 1'b0, go = 1'b0, spi = 1'b0, gen_out_two = 1'b0;
    logic gout2, gout2_oe_n;
    logic recovered_master_clk_out, recovered_master_clk_out_oe_n, ratio_v, wclk, wclk_oe_n, sw_mode, spi_mode, ctl_serial_out, ctl_serial_out_oe_n, low_pow;
    logic ad0, ad1, sclk, sda, busy;
    logic [7:0] tx_byte = 8'h00, host_tx = 8'h00, ratio, host_rx, got_rx;
    logic [2:0] i2c_addr;
    logic [31:0] rnd = 32'h815968DC;
    rcps_cfg_t cfg = '0;
    rcps_sample_t sample = '0;
    rcps_ctl_byte_t ctl_rx;
    int n_errors = 0, comparisons = 0, cyc = 0, n_rx = 0, per;

    rcps_top u_rcps_top (.CLK(clk), .RESET(rst), .CFG(cfg), .PLL_CLK(pll), .PLL_LOCKED(locked),
        .EXT_SYSTEM_CLK_IN(ext), .RECOVERED_MASTER_CLK_OUT(recovered_master_clk_out), .RECOVERED_MASTER_CLK_OE_N(recovered_master_clk_out_oe_n),
        .RATIO(ratio), .RATIO_VALID(ratio_v), .AUDIO_BIT_CLK_IN(1'b0), .AUDIO_BIT_CLK_OUT(),
        .AUDIO_BIT_CLK_OE_N(), .AUDIO_WORD_CLK_IN(1'b0), .AUDIO_WORD_CLK_OUT(wclk),
        .AUDIO_WORD_CLK_OE_N(wclk_oe_n), .AUDIO_SAMPLE(sample), .AUDIO_SERIAL_OUT_IN(strap),
        .AUDIO_SERIAL_OUT(), .AUDIO_SERIAL_OUT_OE_N(), .SOFTWARE_MODE(sw_mode), .SPI_MODE(spi_mode),
        .I2C_ADDR(i2c_addr), .ADDR_PIN_ZERO(ad0), .ADDR_PIN_ONE(ad1), .ADDR_PIN_TWO_IN(ad2),
        .CTL_SHIFT_CLK(sclk), .CTL_DATA_IN(sda), .CTL_SERIAL_OUT(ctl_serial_out), .CTL_SERIAL_OUT_OE_N(ctl_serial_out_oe_n),
        .CTL_TX_BYTE(tx_byte), .CTL_RX(ctl_rx), .GENERAL_OUTPUT_TWO_LEVEL(gen_out_two),
        .GENERAL_OUTPUT_TWO(gout2), .GENERAL_OUTPUT_TWO_OE_N(gout2_oe_n), .LOW_POWER(low_pow));

    rcps_host_model u_rcps_host_model (.clk(clk), .go(go), .use_spi(spi), .tx(host_tx), .strap0(1'b1),
        .strap1(a1), .sdo(ctl_serial_out), .sdo_oe_n(ctl_serial_out_oe_n), .ad0(ad0), .ad1(ad1), .sclk(sclk), .sda(sda),
        .busy(busy), .rx(host_rx));

    // Free-running 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    // Sampled source clocks, received-byte capture, open-drain watch and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pll <= pll_run & cyc[2];
        ext <= ext_run ? cyc[3] : ext_lvl;
        if (ctl_rx.valid === 1'b1) begin
            got_rx <= ctl_rx.data;
            n_rx <= n_rx + 1;
        end
        if (spi_mode !== 1'b1 && ctl_serial_out_oe_n === 1'b0) check(ctl_serial_out, 0, "i2c line driven high");
        if (cyc == 16000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic do_reset(input logic s);
        rst <= 1'b1;
        strap <= s;
        repeat (6) @(posedge clk);
        check(low_pow, 1, "low power in reset");
        check({recovered_master_clk_out_oe_n, wclk_oe_n, ctl_serial_out_oe_n}, 3'h7, "enables in reset");
        rst <= 1'b0;
        repeat (10) @(posedge clk);
    endtask : do_reset

    task automatic xfer(input logic use_spi, input logic [7:0] b);
        host_tx <= b;
        spi <= use_spi;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (int n = 0; n < 400 && busy !== 1'b0; n++) @(posedge clk);
        repeat (8) @(posedge clk);
    endtask : xfer

    // Rise-to-rise distance in cycles of the word clock (w=1) or recovered clock (w=0)
    task automatic period_of(input logic w, output int p);
        int t0;
        logic prev;
        t0 = -1;
        p = 0;
        prev = w ? wclk : recovered_master_clk_out;
        for (int n = 0; n < 5000 && p == 0; n++) begin
            @(posedge clk);
            if ((w ? wclk : recovered_master_clk_out) === 1'b1 && prev === 1'b0) begin
                if (t0 < 0) t0 = cyc;
                else p = cyc - t0;
            end
            prev = w ? wclk : recovered_master_clk_out;
        end
    endtask : period_of

    initial begin
        sample <= {rnd, rnd[15:0]};
        gen_out_two <= rnd[3];
        do_reset(1'b0);
        check(sw_mode, 0, "software mode without strap");
        rnd = lfsr(rnd);
        a1 <= rnd[1];
        ad2 <= rnd[2];
        do_reset(1'b1);
        check(sw_mode, 1, "software mode with strap");
        check(low_pow, 0, "low power after reset");
        check(i2c_addr, {ad2, a1, 1'b1}, "i2c address");
        check(gout2_oe_n, 1, "address-two pin released in i2c");
        $display("test straps done");
        rnd = lfsr(rnd);
        tx_byte <= rnd[15:8];
        xfer(1'b0, rnd[7:0]);
        check(n_rx, 1, "i2c byte count");
        check(got_rx, host_rx, "i2c byte");
        check(spi_mode, 0, "no spi without cs edge");
        $display("test i2c done");
        rnd = lfsr(rnd);
        tx_byte <= rnd[15:8];
        repeat (4) @(posedge clk);
        xfer(1'b1, rnd[7:0]);
        check(spi_mode, 1, "spi after cs edge");
        check(got_rx, rnd[7:0], "spi byte in");
        check(host_rx, rnd[15:8], "spi byte out");
        check(n_rx, 2, "spi byte count");
        check({gout2_oe_n, gout2}, {1'b0, gen_out_two}, "general output driven in spi");
        $display("test spi done");
        locked <= 1'b1;
        pll_run <= 1'b1;
        cfg.word_clk_master <= 1'b1;
        repeat (20) @(posedge clk);
        period_of(1'b0, per);
        check(per, 8, "recovered clock 256x");
        cfg.clk_div_sel <= 1'b1;
        repeat (20) @(posedge clk);
        period_of(1'b0, per);
        check(per, 16, "recovered clock 128x");
        cfg.clk_div_sel <= 1'b0;
        period_of(1'b1, per);
        check(per, 2048, "word clock period");
        check(wclk_oe_n, 0, "word clock driven");
        ext_run <= 1'b1;
        repeat (1600) @(posedge clk);
        check(ratio_v, 1, "ratio valid");
        check(ratio, 8'h20, "ratio half rate");
        $display("test clocks done");
        ext_run <= 1'b0;
        ext_lvl <= 1'b1;
        pll_run <= 1'b0;
        locked <= 1'b0;
        cfg.fallback_en <= 1'b1;
        repeat (10) @(posedge clk);
        check(recovered_master_clk_out, 1, "fallback to system clock");
        locked <= 1'b1;
        repeat (10) @(posedge clk);
        check(recovered_master_clk_out, 0, "back to pll on lock");
        locked <= 1'b0;
        cfg.fallback_en <= 1'b0;
        repeat (10) @(posedge clk);
        check(recovered_master_clk_out, 0, "no fallback when disabled");
        cfg.rx_disable <= 1'b1;
        repeat (6) @(posedge clk);
        check(recovered_master_clk_out_oe_n, 1, "recovered clock released");
        cfg.rx_disable <= 1'b0;
        repeat (6) @(posedge clk);
        check(recovered_master_clk_out_oe_n, 0, "recovered clock driven");
        $display("test fallback and disable done");
        close_out();
    end
endmodule : rcps_top_tb_top

// ---- verilog/rcps_top.sv ----
// Receiver clock outputs, serial audio framing and control-port mode select
`include "rcps_defs.svh"

module rcps_top (
    input  wire logic                    CLK,
    input  wire logic                    RESET,
    input  wire rcps_pkg::rcps_cfg_t     CFG,
    input  wire logic                    PLL_CLK,
    input  wire logic                    PLL_LOCKED,
    input  wire logic                    EXT_SYSTEM_CLK_IN,
    output logic                         RECOVERED_MASTER_CLK_OUT,
    output logic                         RECOVERED_MASTER_CLK_OE_N,
    output logic [7:0]                   RATIO,
    output logic                         RATIO_VALID,
    input  wire logic                    AUDIO_BIT_CLK_IN,
    output logic                         AUDIO_BIT_CLK_OUT,
    output logic                         AUDIO_BIT_CLK_OE_N,
    input  wire logic                    AUDIO_WORD_CLK_IN,
    output logic                         AUDIO_WORD_CLK_OUT,
    output logic                         AUDIO_WORD_CLK_OE_N,
    input  wire rcps_pkg::rcps_sample_t  AUDIO_SAMPLE,
    input  wire logic                    AUDIO_SERIAL_OUT_IN,
    output logic                         AUDIO_SERIAL_OUT,
    output logic                         AUDIO_SERIAL_OUT_OE_N,
    output logic                         SOFTWARE_MODE,
    output logic                         SPI_MODE,
    output logic [2:0]                   I2C_ADDR,
    input  wire logic                    ADDR_PIN_ZERO,
    input  wire logic                    ADDR_PIN_ONE,
    input  wire logic                    ADDR_PIN_TWO_IN,
    input  wire logic                    CTL_SHIFT_CLK,
    input  wire logic                    CTL_DATA_IN,
    output logic                         CTL_SERIAL_OUT,
    output logic                         CTL_SERIAL_OUT_OE_N,
    input  wire logic [7:0]              CTL_TX_BYTE,
    output rcps_pkg::rcps_ctl_byte_t     CTL_RX,
    input  wire logic                    GENERAL_OUTPUT_TWO_LEVEL,
    output logic                         GENERAL_OUTPUT_TWO,
    output logic                         GENERAL_OUTPUT_TWO_OE_N,
    output logic                         LOW_POWER
);
    import rcps_pkg::*;

    // Pin synchronisers; stage one feeds stage two only
    logic [`RCPS_SYNC_W-1:0] sync1;
    logic [`RCPS_SYNC_W-1:0] sync2;
    logic [`RCPS_SYNC_W-1:0] prev;
    wire  [`RCPS_SYNC_W-1:0] pins = {ADDR_PIN_TWO_IN, CTL_DATA_IN, CTL_SHIFT_CLK, ADDR_PIN_ONE, ADDR_PIN_ZERO,
                                     AUDIO_SERIAL_OUT_IN, AUDIO_WORD_CLK_IN, AUDIO_BIT_CLK_IN,
                                     PLL_LOCKED, EXT_SYSTEM_CLK_IN, PLL_CLK};
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sync1 <= '0;
            sync2 <= '0;
            prev  <= '0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    // Named views of the synchronised pins and their edges
    wire pll_rise  = sync2[0] & ~prev[0];
    wire ext_rise  = sync2[1] & ~prev[1];
    wire locked    = sync2[2];
    wire bclk_fall = ~sync2[3] & prev[3];
    wire wclk_edge = sync2[4] ^ prev[4];
    wire strap_pin = sync2[5];
    wire ad0       = sync2[6];
    wire ad0_fall  = ~sync2[6] & prev[6];
    wire ad1       = sync2[7];
    wire ctl_shift_clk_rise = sync2[8] & ~prev[8];
    wire ctl_shift_clk_fall = ~sync2[8] & prev[8];
    wire sda_in    = sync2[9];
    wire ad2       = sync2[10];

    // Clock source select; relock hands the output straight back to the PLL
    wire use_ext  = CFG.fallback_en & ~locked;
    wire src_rise = use_ext ? ext_rise : pll_rise;
    wire src_lvl  = use_ext ? sync2[1] : sync2[0];

    // Base counter in 256x units; clock pins are sampled, so inputs must stay below 25 MHz
    logic [`RCPS_FS_CNT_W-1:0] fs_cnt;
    logic                      half_clk;
    logic                      word_gen;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            fs_cnt   <= '0;
            half_clk <= 1'b0;
        end else if (src_rise) begin
            fs_cnt   <= fs_cnt + 1'b1;
            half_clk <= ~half_clk;
        end
    end
    assign word_gen = fs_cnt[`RCPS_WCLK_BIT];

    // Recovered clock output and its tri-state
    wire next_recovered_master_clk_out = CFG.clk_div_sel ? half_clk : src_lvl;
    logic recovered_master_clk_out_prev;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            RECOVERED_MASTER_CLK_OUT  <= 1'b0;
            RECOVERED_MASTER_CLK_OE_N <= 1'b1;
            recovered_master_clk_out_prev                 <= 1'b0;
        end else begin
            RECOVERED_MASTER_CLK_OUT  <= next_recovered_master_clk_out;
            RECOVERED_MASTER_CLK_OE_N <= CFG.rx_disable;
            recovered_master_clk_out_prev                 <= RECOVERED_MASTER_CLK_OUT;
        end
    end
    wire recovered_master_clk_out_rise = RECOVERED_MASTER_CLK_OUT & ~recovered_master_clk_out_prev;

    // Ratio: system clock edges counted over 64 recovered clock edges, 2.6 fixed point
    logic [5:0] win_cnt;
    logic [7:0] ext_cnt;
    wire        win_end   = recovered_master_clk_out_rise && (win_cnt == `RCPS_RATIO_WIN);
    wire        ext_sat   = (ext_cnt == `RCPS_RATIO_MAX);
    wire [7:0]  next_ext  = ext_cnt + {7'h00, ext_rise & ~ext_sat};
    always_ff @(posedge CLK) begin
        if (RESET) begin
            win_cnt     <= '0;
            ext_cnt     <= '0;
            RATIO       <= '0;
            RATIO_VALID <= 1'b0;
        end else begin
            win_cnt <= win_cnt + {5'h00, recovered_master_clk_out_rise};
            ext_cnt <= win_end ? 8'h00 : next_ext;
            if (win_end) begin
                RATIO       <= next_ext;
                RATIO_VALID <= 1'b1;
            end
        end
    end

    // Audio framing: master uses the base counter, slave follows the pins
    wire gen_bfall  = src_rise && (fs_cnt[`RCPS_BCLK_BIT:0] == 2'h3);
    wire gen_wedge  = src_rise && (fs_cnt[`RCPS_WCLK_BIT-1:0] == 7'h7F);
    wire shift_stb  = CFG.word_clk_master ? gen_bfall : bclk_fall;
    wire frame_stb  = CFG.word_clk_master ? gen_wedge : wclk_edge;
    wire next_wlvl  = CFG.word_clk_master ? ~word_gen : sync2[4];
    logic [31:0] sdo_shift;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sdo_shift <= '0;
        end else if (frame_stb) begin
            // Left half while word clock is low after the edge, left justified
            sdo_shift <= {next_wlvl ? AUDIO_SAMPLE.right : AUDIO_SAMPLE.left, `RCPS_SLOT_PAD};
        end else if (shift_stb) begin
            sdo_shift <= {sdo_shift[30:0], 1'b0};
        end
    end

    // Start-up strap: wait for the synchroniser to fill, then latch once
    logic [1:0] strap_cnt;
    logic       strap_done;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            strap_cnt     <= '0;
            strap_done    <= 1'b0;
            SOFTWARE_MODE <= 1'b0;
        end else if (!strap_done) begin
            strap_cnt <= strap_cnt + 1'b1;
            if (strap_cnt == `RCPS_STRAP_WAIT) begin
                strap_done    <= 1'b1;
                SOFTWARE_MODE <= strap_pin;
            end
        end
    end

    // Audio pin drivers; data pin released until the strap is read
    always_ff @(posedge CLK) begin
        if (RESET) begin
            AUDIO_SERIAL_OUT      <= 1'b0;
            AUDIO_SERIAL_OUT_OE_N <= 1'b1;
            AUDIO_BIT_CLK_OUT     <= 1'b0;
            AUDIO_BIT_CLK_OE_N    <= 1'b1;
            AUDIO_WORD_CLK_OUT    <= 1'b0;
            AUDIO_WORD_CLK_OE_N   <= 1'b1;
        end else begin
            AUDIO_SERIAL_OUT      <= sdo_shift[31];
            AUDIO_SERIAL_OUT_OE_N <= ~strap_done;
            AUDIO_BIT_CLK_OUT     <= fs_cnt[`RCPS_BCLK_BIT];
            AUDIO_BIT_CLK_OE_N    <= ~CFG.word_clk_master;
            AUDIO_WORD_CLK_OUT    <= word_gen;
            AUDIO_WORD_CLK_OE_N   <= ~CFG.word_clk_master;
        end
    end

    // Port mode: sticky SPI after a chip-select fall, address latched in I2C
    always_ff @(posedge CLK) begin
        if (RESET) begin
            SPI_MODE <= 1'b0;
            I2C_ADDR <= '0;
        end else begin
            if (strap_done && ad0_fall) begin
                SPI_MODE <= 1'b1;
            end
            if (!SPI_MODE) begin
                I2C_ADDR <= {ad2, ad1, ad0};
            end
        end
    end

    // Control shifter; I2C start/stop and address match live upstream
    // A chip-select fall deselects for one cycle, so no count or byte left from I2C leaks into the frame
    wire       ctl_sel   = SOFTWARE_MODE & (~SPI_MODE | ~ad0) & ~ad0_fall;
    wire       ctl_din   = SPI_MODE ? ad1 : sda_in;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    wire       byte_done = ctl_sel && ctl_shift_clk_rise && (bit_cnt == `RCPS_BYTE_LAST);
    always_ff @(posedge CLK) begin
        if (RESET) begin
            bit_cnt  <= '0;
            rx_shift <= '0;
            tx_shift <= `RCPS_BYTE_RST;
            CTL_RX   <= '0;
        end else begin
            CTL_RX.valid <= byte_done;
            if (!ctl_sel) begin
                bit_cnt  <= '0;
                tx_shift <= CTL_TX_BYTE;
            end else if (ctl_shift_clk_rise) begin
                bit_cnt  <= bit_cnt + 1'b1;
                rx_shift <= {rx_shift[6:0], ctl_din};
                if (byte_done) begin
                    CTL_RX.data <= {rx_shift[6:0], ctl_din};
                    tx_shift    <= CTL_TX_BYTE;
                end
            end else if (ctl_shift_clk_fall && bit_cnt != 3'h0) begin
                tx_shift <= {tx_shift[6:0], 1'b1};
            end
        end
    end

    // Output data pin: push-pull in SPI, pull-low only in I2C
    wire next_cout   = SPI_MODE ? tx_shift[7] : 1'b0;
    wire next_coe_n  = SPI_MODE ? ~ctl_sel : ~(ctl_sel & ~tx_shift[7]);
    always_ff @(posedge CLK) begin
        if (RESET) begin
            CTL_SERIAL_OUT          <= 1'b0;
            CTL_SERIAL_OUT_OE_N     <= 1'b1;
            GENERAL_OUTPUT_TWO      <= 1'b0;
            GENERAL_OUTPUT_TWO_OE_N <= 1'b1;
            LOW_POWER               <= 1'b1;
        end else begin
            CTL_SERIAL_OUT          <= next_cout;
            CTL_SERIAL_OUT_OE_N     <= next_coe_n;
            GENERAL_OUTPUT_TWO      <= GENERAL_OUTPUT_TWO_LEVEL;
            GENERAL_OUTPUT_TWO_OE_N <= ~SPI_MODE;             // Strap pin left to the board in I2C
            LOW_POWER               <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_fallback_route: assert property (use_ext && CFG.clk_div_sel == 1'b0 |=> RECOVERED_MASTER_CLK_OUT == $past(sync2[1]))
        else $error("system clock not routed while unlocked");
    a_relock_return: assert property (!use_ext && !CFG.clk_div_sel |=> RECOVERED_MASTER_CLK_OUT == $past(sync2[0]))
        else $error("pll clock not restored");
    a_ratio_capture: assert property (win_end |=> RATIO_VALID && RATIO == $past(next_ext))
        else $error("ratio not captured at window end");
    a_div_toggle: assert property (CFG.clk_div_sel && $past(CFG.clk_div_sel) && $changed(next_recovered_master_clk_out) |-> $past(src_rise))
        else $error("divided clock moved without source edge");
    a_recovered_master_clk_out_tristate: assert property (CFG.rx_disable |=> RECOVERED_MASTER_CLK_OE_N)
        else $error("recovered clock driven while disabled");
    a_word_rate: assert property ($changed(word_gen) |-> $past(src_rise) && $past(fs_cnt[6:0]) == 7'h7F)
        else $error("word clock edge off the 128 count");
    a_strap_latch: assert property ($rose(strap_done) |-> SOFTWARE_MODE == $past(strap_pin))
        else $error("software mode differs from strap");
    a_spi_select: assert property (strap_done && ad0_fall |=> SPI_MODE ##1 SPI_MODE)
        else $error("chip select fall missed");
    a_i2c_addr: assert property (!SPI_MODE |=> I2C_ADDR == $past({ad2, ad1, ad0}))
        else $error("i2c address not following pins");
    a_open_drain: assert property (!SPI_MODE |-> CTL_SERIAL_OUT == 1'b0)
        else $error("i2c data line driven high");
    a_byte_shift: assert property (byte_done |=> CTL_RX.valid ##1 !CTL_RX.valid)
        else $error("received byte strobe wrong");
    a_reset_power: assert property (@(posedge CLK) disable iff (1'b0) RESET |=> LOW_POWER && !SOFTWARE_MODE && !SPI_MODE)
        else $error("state not cleared in reset");

    c_spi_entered: cover property (!SPI_MODE ##1 SPI_MODE);
    c_fallback_on: cover property (!use_ext ##1 use_ext ##[1:200] !use_ext);
    c_byte_rx:     cover property (CTL_RX.valid);
    c_ratio_ready: cover property ($rose(RATIO_VALID));
endmodule : rcps_top
